// [design/pbc_counter_latch.sv]
// Presettable four-stage binary counter and transparent latch
`timescale 1ns/1ns
`default_nettype none

module pbc_counter_latch
(
    input  wire logic       clk_sys_i,   // System clock, 20 MHz
    input  wire logic       nrst_i,      // Synchronous reset, active low
    input  wire logic       cnt_clk1_i,  // Count clock of the single stage
    input  wire logic       cnt_clk2_i,  // Count clock of the three-stage section
    input  wire logic       load_n_i,    // Count/load strobe, low loads
    input  wire logic       clr_n_i,     // Direct clear, active low
    input  wire logic [3:0] data_i,      // Preset data
    output logic      [3:0] q_o          // Stage outputs, bit 0 is the single stage
);

    pbc_edge_if edge_if ();

    // Feed count clock levels to the detector
    assign edge_if.clk1_lvl = cnt_clk1_i;
    assign edge_if.clk2_lvl = cnt_clk2_i;

    pbc_fall_det u_fall
    (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .edge_if   (edge_if.det)
    );

    // Stage flip-flops and the count qualifier
    logic                           counting;   // Neither clear nor load is active
    logic                           stage0;     // Single divide-by-two stage
    logic [pbc_pkg::UPPER_BITS-1:0] upper;      // Three-stage section, bit 0 counts fastest

    // Counting only while neither clear nor load is active
    assign counting = clr_n_i & load_n_i;

    // Outputs come straight from the stage flip-flops, one writer per flop
    assign q_o = {upper, stage0};

    // Single divide-by-two stage; its output never clocks the upper section
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            stage0 <= pbc_pkg::Q_RESET[0];
        end
        else if (!clr_n_i)
        begin
            stage0 <= pbc_pkg::Q_RESET[0];
        end
        else if (!load_n_i)
        begin
            stage0 <= data_i[0];
        end
        else if (edge_if.fall1)
        begin
            stage0 <= ~stage0;
        end
    end

    // Three-stage divide-by-eight section, internal ripple folded into one step
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            upper <= pbc_pkg::Q_RESET[3:1];
        end
        else if (!clr_n_i)
        begin
            upper <= pbc_pkg::Q_RESET[3:1];
        end
        else if (!load_n_i)
        begin
            upper <= data_i[3:1];
        end
        else if (edge_if.fall2)
        begin
            upper <= upper + pbc_pkg::UPPER_STEP;
        end
    end

    // Clear forces zero
    property p_clear;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        !clr_n_i |=> (q_o == pbc_pkg::Q_RESET);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero outputs");

    // Clear beats load
    property p_prio;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!clr_n_i && !load_n_i) |=> (q_o == pbc_pkg::Q_RESET);
    endproperty
    a_prio: assert property (p_prio) else $error("load overrode clear");

    // Load copies data
    property p_load;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (clr_n_i && !load_n_i) |=> (q_o == $past(data_i));
    endproperty
    a_load: assert property (p_load) else $error("load did not preset data");

    // Latch holds without clock falls
    property p_hold;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && !edge_if.fall1 && !edge_if.fall2) |=> $stable(q_o);
    endproperty
    a_hold: assert property (p_hold) else $error("latch value changed while idle");

    // Single stage divides by two
    property p_div2;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && edge_if.fall1) |=> (q_o[0] != $past(q_o[0]));
    endproperty
    a_div2: assert property (p_div2) else $error("single stage did not toggle");

    // Upper section steps by one modulo eight
    property p_div8;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && edge_if.fall2) |=> (q_o[3:1] == 3'($past(q_o[3:1]) + 3'h1));
    endproperty
    a_div8: assert property (p_div8) else $error("upper section did not advance");

    // Single stage does not drive the upper section
    property p_indep;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && edge_if.fall1 && !edge_if.fall2) |=> $stable(q_o[3:1]);
    endproperty
    a_indep: assert property (p_indep) else $error("upper section moved on clock one");

    // Rising edge of clock one does not count
    property p_edge;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && cnt_clk1_i && !$past(cnt_clk1_i)) |=> $stable(q_o[0]);
    endproperty
    a_edge: assert property (p_edge) else $error("single stage moved on rising edge");

    // Clear zeroes the single stage even on a clock-one fall
    property p_clr_fall1;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!clr_n_i && edge_if.fall1) |=> (q_o[0] == pbc_pkg::Q_RESET[0]);
    endproperty
    a_clr_fall1: assert property (p_clr_fall1) else $error("clock one beat clear");

    // Clear zeroes the upper section even on a clock-two fall
    property p_clr_fall2;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!clr_n_i && edge_if.fall2) |=> (q_o[3:1] == pbc_pkg::Q_RESET[3:1]);
    endproperty
    a_clr_fall2: assert property (p_clr_fall2) else $error("clock two beat clear");

    // Clear beats load even while a count clock falls
    property p_prio_fall;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!clr_n_i && !load_n_i && (edge_if.fall1 || edge_if.fall2))
            |=> (q_o == pbc_pkg::Q_RESET);
    endproperty
    a_prio_fall: assert property (p_prio_fall) else $error("fall overrode clear");

    // Load wins over any count clock fall
    property p_load_fall;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (clr_n_i && !load_n_i && (edge_if.fall1 || edge_if.fall2))
            |=> (q_o == $past(data_i));
    endproperty
    a_load_fall: assert property (p_load_fall) else $error("fall overrode load");

    // Outputs track each data change while the strobe is low
    property p_follow;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (clr_n_i && !load_n_i && !$stable(data_i)) |=> (q_o == $past(data_i));
    endproperty
    a_follow: assert property (p_follow) else $error("latch did not follow data");

    // Data changes with the strobe high leave the outputs alone
    property p_hold_data;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && !edge_if.fall1 && !edge_if.fall2 && !$stable(data_i)) |=> $stable(q_o);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("outputs moved with strobe high");

    // Rising edge of clock two does not count
    property p_rise2;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && cnt_clk2_i && !$past(cnt_clk2_i)) |=> $stable(q_o[3:1]);
    endproperty
    a_rise2: assert property (p_rise2) else $error("upper section moved on rising edge");

    // Clock two does not disturb the single stage
    property p_indep2;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && edge_if.fall2 && !edge_if.fall1) |=> $stable(q_o[0]);
    endproperty
    a_indep2: assert property (p_indep2) else $error("single stage moved on clock two");

    // A fall on clock one, seen across two edges, moves the single stage
    property p_pin1_fall;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ($past(nrst_i) && counting && $past(cnt_clk1_i) && !cnt_clk1_i) |=> !$stable(q_o[0]);
    endproperty
    a_pin1_fall: assert property (p_pin1_fall) else $error("clock one fall was missed");

    // A fall on clock two, seen across two edges, moves the upper section
    property p_pin2_fall;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ($past(nrst_i) && counting && $past(cnt_clk2_i) && !cnt_clk2_i) |=> !$stable(q_o[3:1]);
    endproperty
    a_pin2_fall: assert property (p_pin2_fall) else $error("clock two fall was missed");

    // Upper section wraps from seven back to zero
    property p_wrap;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (counting && edge_if.fall2 && (q_o[3:1] == 3'h7)) |=> (q_o[3:1] == 3'h0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("upper section did not wrap");

endmodule : pbc_counter_latch

`default_nettype wire

// [design/pbc_pkg.sv]
// Constants shared by the presettable binary counter/latch
// Operation
// - Four flip-flops form one divide-by-two stage and a separate divide-by-eight section.
// - A low count/load strobe presets all four outputs from the data inputs.
// - With the strobe low the outputs follow the data, and with it high and no clock fall they hold.
// - Each stage changes only on a falling edge of the count clock that drives it.
// - A low direct clear forces all four outputs to zero whatever the count clocks do.
// - The first stage does not feed the upper section, so the two parts count independently.
// - Count pulses on the second clock give divide-by-two, four and eight on the upper three outputs.
package pbc_pkg;

    // Number of stages and their split
    localparam int          STAGES     = 4;
    localparam int          UPPER_BITS = 3;

    // Output value after reset or clear
    localparam logic [3:0]  Q_RESET    = 4'h0;
    localparam logic [2:0]  UPPER_STEP = 3'h1;

    // Level held in the edge detector after reset
    localparam logic        LVL_RESET  = 1'b0;

endpackage : pbc_pkg

// [design/pbc_edge_if.sv]
// Carrier between the counter core and its falling-edge detector
`timescale 1ns/1ns
`default_nettype none

interface pbc_edge_if;
    logic clk1_lvl;   // Level of the single-stage count clock
    logic clk2_lvl;   // Level of the three-stage count clock
    logic fall1;      // Falling edge seen on count clock one
    logic fall2;      // Falling edge seen on count clock two

    // Detector side
    modport det
    (
        input  clk1_lvl,
        input  clk2_lvl,
        output fall1,
        output fall2
    );

    // Counter side
    modport user
    (
        output clk1_lvl,
        output clk2_lvl,
        input  fall1,
        input  fall2
    );
endinterface : pbc_edge_if

`default_nettype wire

// [design/pbc_fall_det.sv]
// Falling-edge detector for both count clocks
`timescale 1ns/1ns
`default_nettype none

module pbc_fall_det
(
    input  wire logic clk_sys_i,   // System clock
    input  wire logic nrst_i,      // Synchronous reset, active low
    pbc_edge_if.det   edge_if      // Levels in, fall pulses out
);

    logic prev1;
    logic prev2;

    // Remember last level of each count clock
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            prev1 <= pbc_pkg::LVL_RESET;
            prev2 <= pbc_pkg::LVL_RESET;
        end
        else
        begin
            prev1 <= edge_if.clk1_lvl;
            prev2 <= edge_if.clk2_lvl;
        end
    end

    assign edge_if.fall1 = prev1 & ~edge_if.clk1_lvl;
    assign edge_if.fall2 = prev2 & ~edge_if.clk2_lvl;

endmodule : pbc_fall_det

`default_nettype wire

// [test/pbc_board.sv]
// Board logic that sources the second count clock
`timescale 1ns/1ns
`default_nettype none

module pbc_board
(
    input  wire logic       chain_i,    // Link stage 0 to clock two
    input  wire logic       clk2_i,     // Pulses for the upper section
    input  wire logic [3:0] q_i,        // Counter outputs
    output logic            cnt_clk2_o  // Clock two to the counter
);
    assign cnt_clk2_o = chain_i ? q_i[0] : clk2_i;
endmodule : pbc_board

`default_nettype wire

// [test/pbc_counter_latch_tb_top.sv]
// Self-checking bench for the counter and latch
`timescale 1ns/1ns
`default_nettype none

module pbc_counter_latch_tb_top;
    typedef struct {logic clr_n; logic load_n; logic [3:0] d; logic [3:0] exp;} pbc_row_t;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [1:0] clks = 2'h0;
    logic       clk2;
    logic       chain = 1'b0;
    logic       load_n = 1'b1;
    logic       clr_n = 1'b1;
    logic [3:0] data = 4'h0;
    logic [3:0] q;
    int         miscompares = 0;
    int         compares = 0;
    pbc_row_t   rows [6] = '{'{1'b1, 1'b0, 4'hA, 4'hA}, '{1'b1, 1'b0, 4'h5, 4'h5},
                             '{1'b1, 1'b1, 4'hF, 4'h5}, '{1'b0, 1'b1, 4'hF, 4'h0},
                             '{1'b0, 1'b0, 4'h9, 4'h0}, '{1'b1, 1'b1, 4'h7, 4'h0}};

    // System clock, 50 ns period
    always #25 clk = ~clk;

    pbc_counter_latch uut
    (
        .clk_sys_i  (clk),
        .nrst_i     (nrst),
        .cnt_clk1_i (clks[0]),
        .cnt_clk2_i (clk2),
        .load_n_i   (load_n),
        .clr_n_i    (clr_n),
        .data_i     (data),
        .q_o        (q)
    );

    pbc_board board
    (
        .chain_i    (chain),
        .clk2_i     (clks[1]),
        .q_i        (q),
        .cnt_clk2_o (clk2)
    );

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask : settle

    // One count pulse; the rising half must leave the outputs alone
    task automatic pulse(input int two, input logic [3:0] exp);
        logic [3:0] held;
        held = q;
        clks[two] = 1'b1;
        settle(6);
        check(q, held);
        clks[two] = 1'b0;
        settle(6);
        check(q, exp);
    endtask : pulse

    task automatic stop_test();
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    // Main sequence
    initial
    begin
        settle(12);
        check(q, 4'h0);
        nrst = 1'b1;
        foreach (rows[i])
        begin
            clr_n = rows[i].clr_n;
            load_n = rows[i].load_n;
            data = rows[i].d;
            settle(2);
            check(q, rows[i].exp);
        end
        for (int i = 1; i <= 8; i++)
            pulse(1, {3'(i), 1'b0});
        pulse(0, 4'h1);
        pulse(0, 4'h0);
        chain = 1'b1;
        for (int i = 1; i <= 16; i++)
            pulse(0, 4'(i));
        chain = 1'b0;
        load_n = 1'b0;
        data = 4'h3;
        settle(2);
        pulse(1, 4'h3);
        // Both parts counted apart, then cleared together while both clocks fall
        load_n = 1'b1;
        pulse(0, 4'h2);
        pulse(1, 4'h4);
        clks = 2'h3;
        settle(2);
        check(q, 4'h4);
        clr_n = 1'b0;
        load_n = 1'b0;
        data = 4'hF;
        clks = 2'h0;
        settle(2);
        check(q, 4'h0);
        clr_n = 1'b1;
        data = 4'hC;
        settle(2);
        check(q, 4'hC);
        // Mid-run reset with clock two held high across the release
        load_n = 1'b1;
        clks[1] = 1'b1;
        nrst = 1'b0;
        settle(2);
        check(q, 4'h0);
        nrst = 1'b1;
        settle(2);
        check(q, 4'h0);
        clks[1] = 1'b0;
        settle(2);
        check(q, 4'h2);
        stop_test();
    end

    // Watchdog against a hang
    initial
    begin
        #100000;
        miscompares++;
        stop_test();
    end
endmodule : pbc_counter_latch_tb_top

`default_nettype wire
